// File: src/cie_pkg.sv
// Shared constants and types for the control instruction execution unit
package cie_pkg;
  // Cycle counts per instruction form
  localparam logic [7:0] CYC_NOP = 8'h01;
  localparam logic [7:0] CYC_PREFIX = 8'h01;
  localparam logic [7:0] CYC_PUSH = 8'h03;
  localparam logic [7:0] CYC_POP = 8'h03;
  localparam logic [7:0] CYC_LIST_BASE = 8'h03;
  localparam logic [7:0] CYC_LIST_WORD = 8'h04;
  localparam logic [7:0] CYC_CCR = 8'h03;
  localparam logic [7:0] CYC_SET_CTL = 8'h02;
  localparam logic [7:0] CYC_ADJ = 8'h03;
  localparam logic [7:0] CYC_BRW_ACC = 8'h01;
  localparam logic [7:0] CYC_BRW_IMM = 8'h02;
  localparam logic [7:0] CYC_BRR_FAST = 8'h01;
  localparam logic [7:0] CYC_BRR_DATA = 8'h02;
  localparam logic [7:0] CYC_BRR_PAGE = 8'h03;
  localparam logic [7:0] CYC_LIMIT = 8'h02;
  localparam logic [7:0] CYC_CHECK = 8'h02;
  localparam logic [7:0] CYC_SCAN_ZERO = 8'h03;
  localparam logic [7:0] CYC_SCAN_SET = 8'h05;
  localparam logic [7:0] CYC_CMP_SHORT = 8'h03;
  localparam logic [7:0] CYC_CMP_LONG = 8'h04;
  localparam logic [7:0] CYC_FAST_EXIT = 8'h06;
  localparam logic [7:0] CYC_EXIT_WORD = 8'h04;
  localparam logic [7:0] CYC_EXIT_LONG = 8'h05;
  localparam logic [7:0] CYC_LEA_RW_REG = 8'h03;
  localparam logic [7:0] CYC_LEA_RW_MEM = 8'h02;
  localparam logic [7:0] CYC_LEA_A_REG = 8'h02;
  localparam logic [7:0] CYC_LEA_A_MEM = 8'h01;
  // Status word fields
  localparam int PS_C = 0;
  localparam int PS_V = 1;
  localparam int PS_Z = 2;
  localparam int PS_N = 3;
  localparam int PS_T = 4;
  localparam int PS_S = 5;
  localparam int PS_I = 6;
  localparam int PS_RBP_LSB = 8;
  localparam int PS_ILM_LSB = 13;
  // Reset values and stack step
  localparam logic [15:0] PSW_RST = 16'h0020;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [15:0] LIM_HI_RST = 16'hffff;
  localparam logic [15:0] LIM_LO_RST = 16'h0000;
  localparam logic [15:0] STK_STEP = 16'h0002;
  // Register offsets
  localparam logic [7:0] A_ACC = 8'h00;
  localparam logic [7:0] A_SP = 8'h04;
  localparam logic [7:0] A_PSW = 8'h08;
  localparam logic [7:0] A_BANKS = 8'h0c;
  localparam logic [7:0] A_STKBANKS = 8'h10;
  localparam logic [7:0] A_LIMITS = 8'h14;
  localparam logic [7:0] A_CODE = 8'h18;
  localparam logic [7:0] A_STATE = 8'h1c;

  typedef enum logic [5:0] {
    OP_NOP, OP_PUSH_ACC, OP_PUSH_ACCH, OP_PUSH_STAT, OP_PUSH_LIST,
    OP_POP_ACC, OP_POP_ACCH, OP_POP_STAT, OP_POP_LIST, OP_CC_AND, OP_CC_OR,
    OP_SET_BANKPTR, OP_SET_INTMASK, OP_LEA_RW_REG, OP_LEA_RW_MEM,
    OP_LEA_ACC_REG, OP_LEA_ACC_MEM, OP_ADJ8, OP_ADJ16, OP_BANK_RD,
    OP_BANK_WR_ACC, OP_BANK_WR_IMM, OP_PFX_ADDL, OP_PFX_DATA, OP_PFX_CODE,
    OP_PFX_STACK, OP_PFX_KEEP, OP_PFX_COMMON, OP_LIM_UP, OP_LIM_LO,
    OP_CHK_ON, OP_CHK_OFF, OP_SCAN1, OP_SCAN2, OP_SCAN4, OP_FAST_EXIT,
    OP_EXIT_WORD, OP_EXIT_LONG, OP_CMP_BR
  } cie_op_e;

  typedef enum logic [2:0] {
    BRG_CODE, BRG_ADDL, BRG_SYSSTK, BRG_USRSTK, BRG_STACK, BRG_DATA, BRG_PAGE
  } cie_brg_e;

  typedef enum logic [2:0] {
    SPACE_DEFAULT, SPACE_ADDL, SPACE_DATA, SPACE_CODE, SPACE_STACK
  } cie_space_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM = 3'b010,
    ST_HOLD = 3'b100
  } cie_state_e;

  typedef struct packed {
    cie_op_e op;
    logic [2:0] sel;
    logic [15:0] imm;
    logic [15:0] ea;
    logic [7:0] rlst;
    logic taken;
    logic longf;
    logic [3:0] extra;
  } cie_instr_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cie_mem_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cie_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cie_apb_rsp_s;
endpackage

// File: src/cie_bit_scan.sv
// Bit scan of the low accumulator word with result scaling
`timescale 1ns/10ps
`default_nettype none
module cie_bit_scan (
  input wire logic [15:0] word,
  input wire logic [1:0] scale,
  output logic [7:0] result,
  output logic [7:0] cycles
);
  import cie_pkg::*;

  logic [4:0] pos;

  // Lowest set bit wins; a zero word yields position zero
  always_comb begin
    pos = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (word[i]) begin
        pos = 5'(i);
      end
    end
  end

  assign result = {3'h0, pos} << scale;
  assign cycles = (word == 16'h0000 ? CYC_SCAN_ZERO : CYC_SCAN_SET) + {6'h00, scale};
endmodule
`default_nettype wire

// File: src/cie_exec.sv
// Execution unit for the stack, flag, bank and prefix control instructions
//
// Overview of operation
// - Interrupt pending at fast exit: jump to vector, no stack operations.
// - Word exit pops program counter; long exit also pops the code bank.
// - Compare-and-branch takes one cycle more when taken, plus mode extra.
// - Single word push: stack pointer minus 2, then write, 3 cycles.
// - List push lowers stack pointer 2 per selected register, storing each.
// - Word pop reads at stack pointer then adds 2, 3 cycles.
// - Status pop reloads every flag from the popped word.
// - Condition byte AND or OR with immediate, 3 cycles.
// - Effective address load writes the address, flags untouched.
// - Stack adjust adds sign-extended byte or word immediate, 3 cycles.
// - Bank read zero-extends into the low accumulator word, sets negative and zero.
// - Bank write from accumulator 1 cycle, immediate 2, sets N and Z.
// - Space prefixes redirect the next data access, one cycle each.
// - Keep-flags prefix stops a next bank read, bank write or bit scan changing flags.
// - Common bank prefix makes next instruction use the common bank.
// - Upper and lower stack limits load from immediates, 2 cycles.
// - Stack check enable and disable, 2 cycles, no flag change.
// - Bit scan writes set-bit position, scaled by 2 or 4, sets zero.
// - Bank pointer and interrupt mask loads, 2 cycles, no flags.
// - Bank reads take 1 cycle, data bank 2, direct page 3.
// - Bit scan takes 3 or 5 cycles; scaled forms 4/6 and 5/7.
`timescale 1ns/10ps
`default_nettype none
module cie_exec (
  input wire logic clk,
  input wire logic arst_n,
  input wire cie_pkg::cie_instr_s instr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic irq_pending,
  input wire logic [23:0] irq_vector,
  output var cie_pkg::cie_mem_s mem,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [23:0] code_addr,
  output logic pc_load,
  output logic done,
  output logic branch_taken,
  output var cie_pkg::cie_space_e data_space,
  output logic keep_flags,
  output logic common_bank,
  output logic stack_fault,
  input wire cie_pkg::cie_apb_req_s apb,
  output var cie_pkg::cie_apb_rsp_s apb_rsp
);
  import cie_pkg::*;

  cie_state_e state;
  cie_instr_s cur;
  cie_space_e pfx_space;
  logic [7:0] cnt, need, list_mask, next_need, next_mask;
  logic [31:0] acc, rd_mux, rdata_q;
  logic [15:0] psw, pc_word, lim_hi, lim_lo, sp_cur, stk_addr;
  logic [15:0] stk_ptr [2];
  logic [15:0] rw [16];
  logic [7:0] code_bank, data_bank, addl_bank, sys_bank, usr_bank, page_bank;
  logic [7:0] brg_byte, scan_res, scan_cyc, bank_wv;
  logic [2:0] pick;
  logic [1:0] scan_scale;
  logic chk_en, pfx_keep, pfx_common, accept, acked, is_push, flag_ok;
  logic stk_sel, retire, wr_en, rd_hit;

  function automatic logic [2:0] low_one(input logic [7:0] m);
    low_one = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        low_one = 3'(i);
      end
    end
  endfunction

  function automatic logic [2:0] high_one(input logic [7:0] m);
    high_one = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        high_one = 3'(i);
      end
    end
  endfunction

  function automatic logic [7:0] count_ones(input logic [7:0] m);
    count_ones = 8'h00;
    for (int i = 0; i < 8; i++) begin
      count_ones = count_ones + {7'h00, m[i]};
    end
  endfunction

  // Bank 0 doubles as the common bank
  function automatic logic [3:0] bank_idx(input logic common, input logic [15:0] ps,
                                          input logic [2:0] sel);
    bank_idx = {~common & ps[PS_RBP_LSB], sel};
  endfunction

  function automatic logic [15:0] with_nz(input logic [15:0] ps, input logic [7:0] b);
    with_nz = ps;
    with_nz[PS_N] = b[7];
    with_nz[PS_Z] = (b == 8'h00);
  endfunction

  function automatic logic is_pfx(input cie_op_e op);
    is_pfx = op inside {OP_PFX_ADDL, OP_PFX_DATA, OP_PFX_CODE, OP_PFX_STACK,
                        OP_PFX_KEEP, OP_PFX_COMMON};
  endfunction

  assign instr_ready = (state == ST_IDLE);
  assign accept = instr_valid && instr_ready;
  assign acked = (state == ST_MEM) && mem_ack;
  assign stk_sel = psw[PS_S];
  assign sp_cur = stk_ptr[stk_sel];
  assign is_push = cur.op inside {OP_PUSH_ACC, OP_PUSH_ACCH, OP_PUSH_STAT, OP_PUSH_LIST};
  // Push walks high to low, pop low to high, so a pop undoes a push
  assign pick = is_push ? high_one(list_mask) : low_one(list_mask);
  assign stk_addr = is_push ? sp_cur - STK_STEP : sp_cur;
  assign flag_ok = !pfx_keep;
  assign code_addr = {code_bank, pc_word};
  assign bank_wv = (instr.op == OP_BANK_WR_IMM) ? instr.imm[7:0] : acc[7:0];
  assign scan_scale = (instr.op == OP_SCAN4) ? 2'h2 : (instr.op == OP_SCAN2 ? 2'h1 : 2'h0);

  cie_bit_scan u_scan (
    .word(acc[15:0]),
    .scale(scan_scale),
    .result(scan_res),
    .cycles(scan_cyc)
  );

  always_comb begin
    mem.req = (state == ST_MEM);
    mem.we = is_push;
    mem.addr = {stk_sel ? sys_bank : usr_bank, stk_addr};
    case (cur.op)
      OP_PUSH_ACC: mem.wdata = acc[15:0];
      OP_PUSH_ACCH: mem.wdata = acc[31:16];
      OP_PUSH_STAT: mem.wdata = psw;
      OP_PUSH_LIST: mem.wdata = rw[bank_idx(common_bank, psw, pick)];
      default: mem.wdata = WORD_RST;
    endcase
  end

  always_comb begin
    case (instr.sel)
      BRG_CODE: brg_byte = code_bank;
      BRG_ADDL: brg_byte = addl_bank;
      BRG_SYSSTK: brg_byte = sys_bank;
      BRG_USRSTK: brg_byte = usr_bank;
      BRG_STACK: brg_byte = stk_sel ? sys_bank : usr_bank;
      BRG_DATA: brg_byte = data_bank;
      BRG_PAGE: brg_byte = page_bank;
      default: brg_byte = BANK_RST;
    endcase
  end

  // Length and stack words of the offered instruction
  always_comb begin
    next_need = CYC_NOP;
    next_mask = 8'h00;
    case (instr.op)
      OP_PUSH_ACC, OP_PUSH_ACCH, OP_PUSH_STAT: begin
        next_need = CYC_PUSH;
        next_mask = 8'h01;
      end
      OP_POP_ACC, OP_POP_ACCH, OP_POP_STAT: begin
        next_need = CYC_POP;
        next_mask = 8'h01;
      end
      OP_PUSH_LIST, OP_POP_LIST: begin
        next_need = CYC_LIST_BASE + 8'(CYC_LIST_WORD * count_ones(instr.rlst));
        next_mask = instr.rlst;
      end
      OP_CC_AND, OP_CC_OR: next_need = CYC_CCR;
      OP_SET_BANKPTR, OP_SET_INTMASK: next_need = CYC_SET_CTL;
      OP_LEA_RW_REG: next_need = CYC_LEA_RW_REG;
      OP_LEA_RW_MEM: next_need = CYC_LEA_RW_MEM + {4'h0, instr.extra};
      OP_LEA_ACC_REG: next_need = CYC_LEA_A_REG;
      OP_LEA_ACC_MEM: next_need = CYC_LEA_A_MEM + {4'h0, instr.extra};
      OP_ADJ8, OP_ADJ16: next_need = CYC_ADJ;
      OP_BANK_RD: begin
        if (instr.sel == BRG_DATA) begin
          next_need = CYC_BRR_DATA;
        end else if (instr.sel == BRG_PAGE) begin
          next_need = CYC_BRR_PAGE;
        end else begin
          next_need = CYC_BRR_FAST;
        end
      end
      OP_BANK_WR_ACC: next_need = CYC_BRW_ACC;
      OP_BANK_WR_IMM: next_need = CYC_BRW_IMM;
      OP_PFX_ADDL, OP_PFX_DATA, OP_PFX_CODE, OP_PFX_STACK, OP_PFX_KEEP, OP_PFX_COMMON:
        next_need = CYC_PREFIX;
      OP_LIM_UP, OP_LIM_LO: next_need = CYC_LIMIT;
      OP_CHK_ON, OP_CHK_OFF: next_need = CYC_CHECK;
      OP_SCAN1, OP_SCAN2, OP_SCAN4: next_need = scan_cyc;
      OP_FAST_EXIT: begin
        next_need = CYC_FAST_EXIT;
        next_mask = irq_pending ? 8'h00 : 8'h07;
      end
      OP_EXIT_WORD: begin
        next_need = CYC_EXIT_WORD;
        next_mask = 8'h01;
      end
      OP_EXIT_LONG: begin
        next_need = CYC_EXIT_LONG;
        next_mask = 8'h03;
      end
      OP_CMP_BR: next_need = (instr.longf ? CYC_CMP_LONG : CYC_CMP_SHORT)
                             + {7'h00, instr.taken} + {4'h0, instr.extra};
      default: next_need = CYC_NOP;
    endcase
  end

  assign retire = (accept && next_mask == 8'h00 && next_need <= CYC_NOP)
                  || (state == ST_HOLD && 8'(cnt + 8'h01) >= need);

  // Sequencer: memory words first, then idle cycles up to the length
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      need <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            cnt <= 8'h01;
            need <= next_need;
            if (next_mask != 8'h00) begin
              state <= ST_MEM;
            end else if (next_need > CYC_NOP) begin
              state <= ST_HOLD;
            end
          end
        end
        ST_MEM: begin
          cnt <= 8'(cnt + 8'h01);
          if (acked && (list_mask & ~(8'h01 << pick)) == 8'h00) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt <= 8'(cnt + 8'h01);
          if (retire) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      list_mask <= 8'h00;
      cur <= '0;
    end else if (accept) begin
      list_mask <= next_mask;
      cur <= instr;
    end else if (acked) begin
      list_mask <= list_mask & ~(8'h01 << pick);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      pc_load <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      done <= retire;
      pc_load <= retire && state == ST_HOLD
                 && cur.op inside {OP_FAST_EXIT, OP_EXIT_WORD, OP_EXIT_LONG};
      if (accept) begin
        branch_taken <= instr.op == OP_CMP_BR && instr.taken;
      end
    end
  end

  // Prefix state is pending until the next non-prefix instruction takes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pfx_space <= SPACE_DEFAULT;
      pfx_keep <= 1'b0;
      pfx_common <= 1'b0;
      data_space <= SPACE_DEFAULT;
      keep_flags <= 1'b0;
      common_bank <= 1'b0;
    end else if (accept) begin
      if (is_pfx(instr.op)) begin
        data_space <= SPACE_DEFAULT;
        keep_flags <= 1'b0;
        common_bank <= 1'b0;
        case (instr.op)
          OP_PFX_ADDL: pfx_space <= SPACE_ADDL;
          OP_PFX_DATA: pfx_space <= SPACE_DATA;
          OP_PFX_CODE: pfx_space <= SPACE_CODE;
          OP_PFX_STACK: pfx_space <= SPACE_STACK;
          OP_PFX_KEEP: pfx_keep <= 1'b1;
          default: pfx_common <= 1'b1;
        endcase
      end else begin
        data_space <= pfx_space;
        keep_flags <= pfx_keep;
        common_bank <= pfx_common;
        pfx_space <= SPACE_DEFAULT;
        pfx_keep <= 1'b0;
        pfx_common <= 1'b0;
      end
    end
  end

  // Instruction writes win over a software write in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psw <= PSW_RST;
    end else if (accept) begin
      case (instr.op)
        OP_CC_AND: psw[7:0] <= psw[7:0] & instr.imm[7:0];
        OP_CC_OR: psw[7:0] <= psw[7:0] | instr.imm[7:0];
        OP_SET_BANKPTR: psw[PS_RBP_LSB +: 5] <= instr.imm[4:0];
        OP_SET_INTMASK: psw[PS_ILM_LSB +: 3] <= instr.imm[2:0];
        OP_BANK_RD: if (flag_ok) psw <= with_nz(psw, brg_byte);
        OP_BANK_WR_ACC, OP_BANK_WR_IMM: if (flag_ok) psw <= with_nz(psw, bank_wv);
        OP_SCAN1, OP_SCAN2, OP_SCAN4: if (flag_ok) psw[PS_Z] <= acc[15:0] == 16'h0000;
        default: psw <= psw;
      endcase
    end else if (acked && (cur.op == OP_POP_STAT || (cur.op == OP_FAST_EXIT && pick == 3'h2))) begin
      psw <= mem_rdata;
    end else if (wr_en && apb.paddr == A_PSW) begin
      psw <= apb.pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= ACC_RST;
    end else if (accept) begin
      case (instr.op)
        OP_LEA_ACC_REG, OP_LEA_ACC_MEM: acc[15:0] <= instr.ea;
        OP_BANK_RD: acc[15:0] <= {8'h00, brg_byte};
        OP_SCAN1, OP_SCAN2, OP_SCAN4: acc[15:0] <= {8'h00, scan_res};
        default: acc <= acc;
      endcase
    end else if (acked && cur.op == OP_POP_ACC) begin
      acc[15:0] <= mem_rdata;
    end else if (acked && cur.op == OP_POP_ACCH) begin
      acc[31:16] <= mem_rdata;
    end else if (wr_en && apb.paddr == A_ACC) begin
      acc <= apb.pwdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) begin
        rw[i] <= WORD_RST;
      end
    end else if (accept && instr.op inside {OP_LEA_RW_REG, OP_LEA_RW_MEM}) begin
      rw[bank_idx(pfx_common, psw, instr.sel)] <= instr.ea;
    end else if (acked && cur.op == OP_POP_LIST) begin
      rw[bank_idx(common_bank, psw, pick)] <= mem_rdata;
    end
  end

  // A status pop moves the stack select only after its own step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stk_ptr[0] <= WORD_RST;
      stk_ptr[1] <= WORD_RST;
    end else if (accept && instr.op == OP_ADJ8) begin
      stk_ptr[stk_sel] <= sp_cur + {{8{instr.imm[7]}}, instr.imm[7:0]};
    end else if (accept && instr.op == OP_ADJ16) begin
      stk_ptr[stk_sel] <= sp_cur + instr.imm;
    end else if (acked) begin
      stk_ptr[stk_sel] <= is_push ? stk_addr : sp_cur + STK_STEP;
    end else if (wr_en && apb.paddr == A_SP) begin
      stk_ptr[stk_sel] <= apb.pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_bank <= BANK_RST;
      data_bank <= BANK_RST;
      addl_bank <= BANK_RST;
      sys_bank <= BANK_RST;
      usr_bank <= BANK_RST;
      page_bank <= BANK_RST;
    end else if (accept && instr.op inside {OP_BANK_WR_ACC, OP_BANK_WR_IMM}) begin
      case (instr.sel)
        BRG_CODE: code_bank <= bank_wv;
        BRG_ADDL: addl_bank <= bank_wv;
        BRG_SYSSTK: sys_bank <= bank_wv;
        BRG_USRSTK: usr_bank <= bank_wv;
        BRG_STACK: if (stk_sel) sys_bank <= bank_wv; else usr_bank <= bank_wv;
        BRG_DATA: data_bank <= bank_wv;
        default: page_bank <= bank_wv;
      endcase
    end else if (accept && instr.op == OP_FAST_EXIT && irq_pending) begin
      code_bank <= irq_vector[23:16];
    end else if (acked && pick == 3'h1 && cur.op inside {OP_EXIT_LONG, OP_FAST_EXIT}) begin
      code_bank <= mem_rdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_word <= WORD_RST;
    end else if (accept && instr.op == OP_FAST_EXIT && irq_pending) begin
      pc_word <= irq_vector[15:0];
    end else if (acked && pick == 3'h0
                 && cur.op inside {OP_FAST_EXIT, OP_EXIT_WORD, OP_EXIT_LONG}) begin
      pc_word <= mem_rdata;
    end
  end

  // Out-of-range pointer is flagged, not trapped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lim_hi <= LIM_HI_RST;
      lim_lo <= LIM_LO_RST;
      chk_en <= 1'b0;
      stack_fault <= 1'b0;
    end else begin
      if (accept && instr.op == OP_LIM_UP) begin
        lim_hi <= instr.imm;
      end
      if (accept && instr.op == OP_LIM_LO) begin
        lim_lo <= instr.imm;
      end
      if (accept && instr.op == OP_CHK_ON) begin
        chk_en <= 1'b1;
      end else if (accept && instr.op == OP_CHK_OFF) begin
        chk_en <= 1'b0;
      end
      stack_fault <= chk_en && (sp_cur > lim_hi || sp_cur < lim_lo);
    end
  end

  // Register bus slave, always ready, read data caught in setup
  assign wr_en = apb.psel && apb.penable && apb.pwrite;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb.psel && apb.penable && !rd_hit;
  assign apb_rsp.prdata = rdata_q;

  always_comb begin
    rd_hit = 1'b1;
    case (apb.paddr)
      A_ACC: rd_mux = acc;
      A_SP: rd_mux = {16'h0000, sp_cur};
      A_PSW: rd_mux = {16'h0000, psw};
      A_BANKS: rd_mux = {data_bank, addl_bank, code_bank, page_bank};
      A_STKBANKS: rd_mux = {16'h0000, usr_bank, sys_bank};
      A_LIMITS: rd_mux = {lim_hi, lim_lo};
      A_CODE: rd_mux = {8'h00, code_bank, pc_word};
      A_STATE: rd_mux = {24'h000000, data_space, common_bank, keep_flags,
                         stack_fault, chk_en, ~instr_ready};
      default: begin
        rd_hit = 1'b0;
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (apb.psel && !apb.penable && !apb.pwrite) begin
      rdata_q <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// File: verification/cie_exec_checker.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/10ps
`default_nettype none
module cie_exec_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire cie_pkg::cie_instr_s instr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic irq_pending,
  input wire cie_pkg::cie_mem_s mem,
  input wire logic mem_ack,
  input wire logic done
);
  import cie_pkg::*;
  logic acc;
  cie_op_e op;
  assign acc = instr_valid && instr_ready;
  assign op = instr.op;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_push; acc && op == OP_PUSH_ACC |=> mem.req && mem.we; endproperty
  a_push: assert property (p_push) else $error("push gave no write");
  property p_hold; mem.req && !mem_ack |=> $stable(mem); endproperty
  a_hold: assert property (p_hold) else $error("stack access moved");
  property p_irq; acc && op == OP_FAST_EXIT && irq_pending |=> !mem.req [*5]; endproperty
  a_irq: assert property (p_irq) else $error("stack used on irq exit");
  property p_br; acc && op == OP_CMP_BR && instr.taken && !instr.longf
    && instr.extra == 4'h0 |-> ##4 done; endproperty
  a_br: assert property (p_br) else $error("taken branch count");
  property p_cc; acc && (op == OP_CC_AND || op == OP_CC_OR) |-> ##3 done; endproperty
  a_cc: assert property (p_cc) else $error("flag logic count");
  property p_ctl; acc && (op == OP_SET_BANKPTR || op == OP_SET_INTMASK) |-> ##2 done; endproperty
  a_ctl: assert property (p_ctl) else $error("control load count");
  property p_lim; acc && (op == OP_LIM_UP || op == OP_LIM_LO) |-> ##2 done; endproperty
  a_lim: assert property (p_lim) else $error("limit load count");
  property p_chk; acc && (op == OP_CHK_ON || op == OP_CHK_OFF) |-> ##2 done; endproperty
  a_chk: assert property (p_chk) else $error("check switch count");
  property p_pfx; acc && op >= OP_PFX_ADDL && op <= OP_PFX_COMMON |-> ##1 done; endproperty
  a_pfx: assert property (p_pfx) else $error("prefix count");
  cover property (mem.req && !mem_ack);
  cover property (acc && op == OP_FAST_EXIT && irq_pending);
  cover property (acc && op == OP_POP_STAT);
endmodule
bind cie_exec cie_exec_checker cie_exec_checker_inst (.clk, .arst_n, .instr, .instr_valid,
  .instr_ready, .irq_pending, .mem, .mem_ack, .done);
`default_nettype wire

// File: verification/cie_mem_model.sv
// Stack memory model with optional wait states
`timescale 1ns/10ps
`default_nettype none
module cie_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire cie_pkg::cie_mem_s mem,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  import cie_pkg::*;
  logic [15:0] ram [256];
  logic [1:0] wt;
  assign mem_ack = mem.req && (!slow || wt == 2'h3);
  // Idle data keeps moving so a stale word never looks valid
  assign mem_rdata = (mem_ack && !mem.we) ? ram[mem.addr[8:1]] : 16'h5a5a ^ {16{clk}};
  always_ff @(posedge clk) begin
    wt <= (mem.req && !mem_ack) ? wt + 2'h1 : 2'h0;
    if (mem_ack && mem.we) begin
      ram[mem.addr[8:1]] <= mem.wdata;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_cpu_control_instr_exec.sv
// Self-checking bench for the control instruction execution unit
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_control_instr_exec;
  import cie_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, irq_pending = 1'b0, slow = 1'b0;
  logic [23:0] irq_vector = 24'h12_3456;
  cie_instr_s instr = '0;
  cie_apb_req_s apb = '0;
  cie_mem_s mem;
  cie_space_e data_space;
  cie_apb_rsp_s apb_rsp;
  logic [15:0] mem_rdata;
  logic [23:0] code_addr;
  logic instr_ready, mem_ack, pc_load, done, branch_taken, keep_flags, common_bank, stack_fault;
  logic [31:0] q;
  logic e;
  int fails = 0, compares = 0;
  cie_exec cie_exec_inst (.clk, .arst_n, .instr, .instr_valid, .instr_ready, .irq_pending,
    .irq_vector, .mem, .mem_rdata, .mem_ack, .code_addr, .pc_load, .done, .branch_taken,
    .data_space, .keep_flags, .common_bank, .stack_fault, .apb, .apb_rsp);
  cie_mem_model cie_mem_model_inst (.clk, .slow, .mem, .mem_rdata, .mem_ack);
  initial forever #10 clk = !clk;
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    fails++;
    $display("wrong value at %0t: timeout", $time);
    report_and_stop();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) hang();
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // One-edge offer; previous op has finished
  task automatic exec(input cie_op_e op, input logic [15:0] imm, input logic tk);
    int n;
    n = 0;
    @(posedge clk);
    instr <= '{op, 3'h0, imm, imm, 8'h0, tk, 1'b0, 4'h0};
    instr_valid <= 1'b1;
    irq_pending <= tk;
    @(posedge clk);
    instr_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      if (n > 40) hang();
    end while (done !== 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(A_PSW, {16'h0, PSW_RST});
    rd(A_LIMITS, {LIM_HI_RST, LIM_LO_RST});
    bus(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    bus(1'b1, A_ACC, 32'h0000_1234);
    slow <= 1'b1;
    exec(OP_PUSH_ACC, 16'h0, 1'b0);
    rd(A_SP, 32'h0000_fffe);
    slow <= 1'b0;
    bus(1'b1, A_ACC, 32'h0);
    exec(OP_POP_ACC, 16'h0, 1'b0);
    rd(A_ACC, 32'h0000_1234);
    rd(A_SP, 32'h0);
    exec(OP_PUSH_STAT, 16'h0, 1'b0);
    bus(1'b1, A_PSW, 32'h0000_007f);
    exec(OP_POP_STAT, 16'h0, 1'b0);
    rd(A_PSW, {16'h0, PSW_RST});
    exec(OP_ADJ8, 16'h00fe, 1'b0);
    rd(A_SP, 32'h0000_fffe);
    exec(OP_ADJ16, 16'h0102, 1'b0);
    rd(A_SP, 32'h0000_0100);
    exec(OP_CC_OR, 16'h0055, 1'b0);
    rd(A_PSW, 32'h0000_0075);
    exec(OP_CC_AND, 16'h003c, 1'b0);
    rd(A_PSW, 32'h0000_0034);
    exec(OP_SET_BANKPTR, 16'h0001, 1'b0);
    exec(OP_SET_INTMASK, 16'h0005, 1'b0);
    rd(A_PSW, 32'h0000_a134);
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, A_ACC, 32'h0000_0028);
      exec(cie_op_e'(OP_SCAN1 + s), 16'h0, 1'b0);
      rd(A_ACC, 32'h3 << s);
    end
    for (int i = 0; i < 6; i++) begin
      exec(cie_op_e'(OP_PFX_ADDL + i), 16'h0, 1'b0);
      exec(OP_NOP, 16'h0, 1'b0);
      chk({data_space, keep_flags, common_bank}, i < 4 ? i * 4 + 4 : 6 - i);
    end
    exec(OP_LIM_UP, 16'h0200, 1'b0);
    exec(OP_LIM_LO, 16'h0100, 1'b0);
    rd(A_LIMITS, 32'h0200_0100);
    exec(OP_CHK_ON, 16'h0, 1'b0);
    exec(OP_ADJ8, 16'h00fe, 1'b0);
    rd(A_STATE, 32'h6);
    exec(OP_CHK_OFF, 16'h0, 1'b0);
    rd(A_STATE, 32'h0);
    exec(OP_LEA_ACC_REG, 16'h0180, 1'b0);
    exec(OP_BANK_WR_ACC, 16'h0, 1'b0);
    exec(OP_BANK_RD, 16'h0, 1'b0);
    rd(A_ACC, 32'h0000_0080);
    exec(OP_CMP_BR, 16'h0, 1'b1);
    chk(branch_taken, 32'h1);
    exec(OP_FAST_EXIT, 16'h0, 1'b1);
    chk(code_addr, irq_vector);
    chk(pc_load, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
